// ===== conv_gain_pkg.sv
package conv_gain_pkg;
    // Bus and datapath widths.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int ACC_W = 32;
    localparam int FIELD_W = 20;
    localparam int GAIN_W = 4;
    localparam int PROD_W = 24;
    localparam int OUT_W = 16;
    localparam int PIX_W = 8;
    localparam int HALF_W = 16;
    // Shift between neighbouring windows.
    localparam int FIELD_STEP = 4;
    // Sign-bit group lengths tested by automatic selection.
    localparam int SIGN_A = 13;
    localparam int SIGN_B = 9;
    localparam int SIGN_C = 5;
    // Line syncs to wait after the program strobe falls.
    localparam logic [3:0] FLUSH_LINES = 4'hA;
    // Pipeline depths.
    localparam int PIX_DLY = 4;
    localparam int EXP_DLY = 4;
    // Deepest store delay: the input delay plus the largest expansion delay.
    localparam int LINE_DLY_MAX = 16;
    // Register offsets.
    localparam logic [3:0] MODE_A_ADDR = 4'h0;
    localparam logic [3:0] MODE_B_ADDR = 4'h1;
    localparam logic [3:0] MODE_C_ADDR = 4'h2;
    localparam logic [3:0] MODE_D_ADDR = 4'h3;
    localparam logic [3:0] SCALE_ADDR = 4'h6;
    localparam logic [3:0] STATUS_ADDR = 4'h9;
    // Field positions.
    localparam int A_NOMUX_BIT = 7;
    localparam int A_EXPOFF_BIT = 0;
    localparam int A_EXPDLY_BIT = 1;
    localparam int A_MASTER_BIT = 2;
    localparam int B_PIXDLY_BIT = 3;
    localparam int C_SEL_LO = 4;
    localparam int C_AUTO_BIT = 6;
    localparam int C_SATPOS_BIT = 0;
    localparam int C_SATBOTH_BIT = 1;
    localparam int C_BYPASS_BIT = 2;
    localparam int D_DLY_LO = 2;
    // Reset values.
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [3:0] SCALE_RST = 4'h1;
    // Output extremes.
    localparam logic [15:0] OUT_MAXPOS = 16'h7FFF;
    localparam logic [15:0] OUT_MAXNEG = 16'h8000;
endpackage

// ===== convolver_gain_and_expansion.sv
`timescale 1ns/1ps
module convolver_gain_and_expansion
    import conv_gain_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input wire logic program_strobe_n,
    input wire logic line_sync_input,
    input wire logic cascadeHeadN,
    input wire logic [ACC_W-1:0] accResult,
    input wire logic [HALF_W-1:0] expInHalf,
    input wire logic expPhaseHigh,
    input wire logic [PIX_W-1:0] pixelIn,
    output logic [PIX_W-1:0] line_delay_pixel_bus,
    output logic [OUT_W-1:0] resultOut,
    output logic [HALF_W-1:0] expOutHalf,
    output logic [1:0] field_indicator,
    output logic overflowFlag,
    output logic masterMode,
    output logic [PIX_W-1:0] storePixel
);
    // Mode registers and gain value, written by software.
    logic [7:0] modeA_q;
    logic [7:0] modeB_q;
    logic [7:0] modeC_q;
    logic [7:0] modeD_q;
    logic [GAIN_W-1:0] scale_q;
    // Synchronisers for the asynchronous pins.
    logic [1:0] progSync_q;
    logic [1:0] syncSync_q;
    logic [1:0] headSync_q;
    logic [1:0] phaseSync_q;
    logic progPrev_q;
    logic syncPrev_q;
    // Accumulator plus expansion input; gain and auto selection both work on it.
    logic [ACC_W-1:0] cascadeSum;

    // Register writes; the bus never stalls.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            modeA_q <= MODE_RST;
            modeB_q <= MODE_RST;
            modeC_q <= MODE_RST;
            modeD_q <= MODE_RST;
            scale_q <= SCALE_RST;
        end else if (regWr) begin
            case (regAddr)
                MODE_A_ADDR: modeA_q <= regWrData[7:0];
                MODE_B_ADDR: modeB_q <= regWrData[7:0];
                MODE_C_ADDR: modeC_q <= regWrData[7:0];
                MODE_D_ADDR: modeD_q <= regWrData[7:0];
                SCALE_ADDR: scale_q <= regWrData[GAIN_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Two-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            progSync_q <= 2'h3;
            syncSync_q <= 2'h3;
            headSync_q <= 2'h3;
            phaseSync_q <= 2'h0;
            progPrev_q <= 1'b1;
            syncPrev_q <= 1'b1;
        end else begin
            progSync_q <= {progSync_q[0], program_strobe_n};
            syncSync_q <= {syncSync_q[0], line_sync_input};
            headSync_q <= {headSync_q[0], cascadeHeadN};
            phaseSync_q <= {phaseSync_q[0], expPhaseHigh};
            progPrev_q <= progSync_q[1];
            syncPrev_q <= syncSync_q[1];
        end
    end

    // Program strobe becoming active (falling) and line sync going low.
    logic progFall;
    logic syncFall;
    assign progFall = progPrev_q & ~progSync_q[1];
    assign syncFall = syncPrev_q & ~syncSync_q[1];

    // Master flag is the low cascade-head pin or the mode A master bit, sampled each cycle.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            masterMode <= 1'b0;
        end else begin
            masterMode <= ~headSync_q[1] | modeA_q[A_MASTER_BIT];
        end
    end

    // Raw auto field request from sign-bit groups; 0 is the topmost window.
    logic [1:0] autoRaw;
    always_comb begin
        if (&cascadeSum[ACC_W-1 -: SIGN_A] || ~|cascadeSum[ACC_W-1 -: SIGN_A]) begin
            autoRaw = 2'h3;
        end else if (&cascadeSum[ACC_W-1 -: SIGN_B] || ~|cascadeSum[ACC_W-1 -: SIGN_B]) begin
            autoRaw = 2'h2;
        end else if (&cascadeSum[ACC_W-1 -: SIGN_C] || ~|cascadeSum[ACC_W-1 -: SIGN_C]) begin
            autoRaw = 2'h1;
        end else begin
            autoRaw = 2'h0;
        end
    end

    // Auto selection: held at the lowest window during flush, then only climbs.
    logic [3:0] flushCnt_q;
    logic [1:0] autoSel_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flushCnt_q <= FLUSH_LINES;
            autoSel_q <= 2'h3;
        end else if (progFall) begin
            flushCnt_q <= FLUSH_LINES;
            autoSel_q <= 2'h3;
        end else if (flushCnt_q != 4'h0) begin
            if (syncFall) begin
                flushCnt_q <= flushCnt_q - 4'h1;
            end
        end else if (autoRaw < autoSel_q) begin
            autoSel_q <= autoRaw;
        end
    end

    // Field indicator always tracks the auto choice.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            field_indicator <= 2'h3;
        end else begin
            field_indicator <= autoSel_q;
        end
    end

    // Window extraction and gain multiply.
    logic [1:0] sel;
    logic [FIELD_W-1:0] field;
    logic [PROD_W-1:0] product;
    logic [OUT_W-1:0] midBits;
    logic topDisagree;
    assign sel = modeC_q[C_AUTO_BIT] ? autoSel_q : modeC_q[C_SEL_LO +: 2];
    always_comb begin
        case (sel)
            2'h0: field = cascadeSum[31:12];
            2'h1: field = cascadeSum[27:8];
            2'h2: field = cascadeSum[23:4];
            default: field = cascadeSum[19:0];
        endcase
    end
    assign product = PROD_W'({{GAIN_W{field[FIELD_W-1]}}, field} * {20'h00000, scale_q});
    assign midBits = product[PROD_W-GAIN_W-1 -: OUT_W];
    assign topDisagree = !(&product[PROD_W-1 -: 5] || ~|product[PROD_W-1 -: 5]);

    // Expansion input: rebuild the 32-bit word from its two phases.
    // Phases alternate on every clock, so the two-cycle synchroniser lag keeps
    // their parity; a phase signal that does not alternate would pair wrong halves.
    logic [HALF_W-1:0] expLow_q;
    logic [ACC_W-1:0] expWord_q;
    logic [ACC_W-1:0] expPipe_q [EXP_DLY];
    logic [ACC_W-1:0] expUse;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            expLow_q <= 16'h0000;
            expWord_q <= 32'h00000000;
        end else if (modeA_q[A_NOMUX_BIT]) begin
            expWord_q <= {16'h0000, expInHalf};
        end else if (phaseSync_q[1]) begin
            expLow_q <= expInHalf;
        end else begin
            expWord_q <= {expInHalf, expLow_q};
        end
    end

    // Optional extra four-clock expansion delay, one generate stage per tap.
    genvar gi;
    generate
        for (gi = 0; gi < EXP_DLY; gi++) begin : gExp
            if (gi == 0) begin : gFirst
                // The first tap takes the rebuilt word from the expWord_q register.
                always_ff @(posedge clock or negedge rstn) begin
                    if (!rstn) begin
                        expPipe_q[gi] <= 32'h00000000;
                    end else begin
                        expPipe_q[gi] <= expWord_q;
                    end
                end
            end else begin : gNext
                // Later taps only look one tap back, so no index leaves the array.
                always_ff @(posedge clock or negedge rstn) begin
                    if (!rstn) begin
                        expPipe_q[gi] <= 32'h00000000;
                    end else begin
                        expPipe_q[gi] <= expPipe_q[gi-1];
                    end
                end
            end
        end
    endgenerate
    assign expUse = modeA_q[A_EXPDLY_BIT] ? expPipe_q[EXP_DLY-1] : expWord_q;

    // Cascade sum; only the mode A A_EXPOFF_BIT gates the adder off, not the master flag.
    assign cascadeSum = modeA_q[A_EXPOFF_BIT] ? accResult : accResult + expUse;

    // Output stage: saturation, overflow and bypass selection.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resultOut <= 16'h0000;
            overflowFlag <= 1'b0;
        end else if (modeA_q[A_NOMUX_BIT]) begin
            overflowFlag <= 1'b0;
            resultOut <= modeC_q[C_BYPASS_BIT] ? cascadeSum[15:0] : midBits;
        end else begin
            overflowFlag <= topDisagree;
            if (modeC_q[C_SATPOS_BIT]) begin
                if (product[PROD_W-1]) begin
                    resultOut <= 16'h0000;
                end else if (topDisagree) begin
                    resultOut <= OUT_MAXPOS;
                end else begin
                    resultOut <= midBits;
                end
            end else if (modeC_q[C_SATBOTH_BIT] && topDisagree) begin
                resultOut <= product[PROD_W-1] ? OUT_MAXNEG : OUT_MAXPOS;
            end else begin
                resultOut <= midBits;
            end
        end
    end

    // Expansion output: low half in the high phase, high half in the low phase.
    // The flop lands one cycle late, so it prepares the half for the coming phase.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            expOutHalf <= 16'h0000;
        end else if (modeA_q[A_NOMUX_BIT] || !phaseSync_q[1]) begin
            expOutHalf <= cascadeSum[15:0];
        end else begin
            expOutHalf <= cascadeSum[31:16];
        end
    end

    // Pixel delay line feeding the line stores; total taps are the sum of
    // the optional four-clock input delay and the mode D expansion delay.
    logic [PIX_W-1:0] pixPipe_q [LINE_DLY_MAX+1];
    // Five bits, since the sum of both delays reaches sixteen taps.
    logic [4:0] totalDly;
    assign totalDly = (modeB_q[B_PIXDLY_BIT] ? 5'h04 : 5'h00)
        + {1'b0, modeD_q[D_DLY_LO +: 2], 2'h0};
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pixPipe_q[0] <= 8'h00;
        end else begin
            pixPipe_q[0] <= pixelIn;
        end
    end
    generate
        for (gi = 1; gi <= LINE_DLY_MAX; gi++) begin : gPix
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    pixPipe_q[gi] <= 8'h00;
                end else begin
                    pixPipe_q[gi] <= pixPipe_q[gi-1];
                end
            end
        end
    endgenerate
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            storePixel <= 8'h00;
        end else begin
            storePixel <= pixPipe_q[totalDly];
        end
    end

    // Line-delay bus: stays zero until the fifth edge after sync falls.
    logic [2:0] edgeCnt_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            edgeCnt_q <= 3'h0;
            line_delay_pixel_bus <= 8'h00;
        end else begin
            if (syncFall) begin
                edgeCnt_q <= 3'h1;
            end else if (edgeCnt_q != 3'h0 && edgeCnt_q != 3'h5) begin
                edgeCnt_q <= edgeCnt_q + 3'h1;
            end
            // A new sync blanks the bus at once, so the old line cannot leak on.
            line_delay_pixel_bus <= !syncFall && ((edgeCnt_q == 3'h4) || (edgeCnt_q == 3'h5))
                ? pixPipe_q[3] : 8'h00;
        end
    end

    // Register read; status shows the block's own state, unmapped reads zero.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                MODE_A_ADDR: regRdData <= {24'h000000, modeA_q};
                MODE_B_ADDR: regRdData <= {24'h000000, modeB_q};
                MODE_C_ADDR: regRdData <= {24'h000000, modeC_q};
                MODE_D_ADDR: regRdData <= {24'h000000, modeD_q};
                SCALE_ADDR: regRdData <= {28'h0000000, scale_q};
                STATUS_ADDR: regRdData <= {24'h000000, flushCnt_q, overflowFlag,
                    masterMode, field_indicator};
                default: regRdData <= 32'h00000000;
            endcase
        end else begin
            regRdData <= 32'h00000000;
        end
    end

    // Assertions next to the logic above.
    program_clear_a: assert property (@(posedge clock) disable iff (!rstn)
        progFall |=> (flushCnt_q == FLUSH_LINES && autoSel_q == 2'h3))
        else $error("auto selection not cleared by program strobe");
    auto_climb_a: assert property (@(posedge clock) disable iff (!rstn)
        !progFall |=> autoSel_q <= $past(autoSel_q))
        else $error("auto selection moved to a less significant window");
    field_track_a: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> field_indicator == $past(autoSel_q))
        else $error("field indicator does not follow auto choice");
    flush_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        (flushCnt_q != 4'h0 && !progFall) |=> autoSel_q == 2'h3)
        else $error("auto choice moved during flush");
    overflow_set_a: assert property (@(posedge clock) disable iff (!rstn)
        (!modeA_q[A_NOMUX_BIT] && topDisagree) |=> overflowFlag)
        else $error("overflow not flagged");
    sat_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        (!modeA_q[A_NOMUX_BIT] && modeC_q[C_SATPOS_BIT] && product[PROD_W-1])
        |=> resultOut == 16'h0000)
        else $error("negative output not forced to zero");
    sat_both_a: assert property (@(posedge clock) disable iff (!rstn)
        (!modeA_q[A_NOMUX_BIT] && !modeC_q[C_SATPOS_BIT] && modeC_q[C_SATBOTH_BIT]
        && topDisagree && !product[PROD_W-1]) |=> resultOut == OUT_MAXPOS)
        else $error("positive overflow not clamped");
    nomux_flag_a: assert property (@(posedge clock) disable iff (!rstn)
        modeA_q[A_NOMUX_BIT] |=> !overflowFlag)
        else $error("overflow reported without multiplexing");
    line_fifth_a: assert property (@(posedge clock) disable iff (!rstn)
        syncFall |=> (line_delay_pixel_bus == 8'h00) [*4])
        else $error("line pixel appeared before fifth edge");
    master_pin_a: assert property (@(posedge clock) disable iff (!rstn)
        !headSync_q[1] |=> masterMode)
        else $error("low cascade head pin did not make a master");
    nomux_raw_a: assert property (@(posedge clock) disable iff (!rstn)
        (modeA_q[A_NOMUX_BIT] && modeC_q[C_BYPASS_BIT])
        |=> resultOut == $past(cascadeSum[15:0]))
        else $error("bypass output is not the raw low sum");
endmodule

// ===== cascade_partner.sv
`timescale 1ns/1ps
// Upstream neighbour in a cascade. It puts its 32-bit partial sum on the
// shared 16-bit expansion bus, one half per clock phase.
module cascade_partner (
    input wire logic clock,
    input wire logic [31:0] sumWord,
    input wire logic noMux,
    output logic [15:0] expInHalf,
    output logic expPhaseHigh
);
    // The pixel clock phase is a level that flips on every rising edge of the fast clock.
    // With multiplexing off it stays high and only the low half travels.
    logic phaseQ = 1'b0;
    always @(posedge clock) begin
        phaseQ <= noMux | ~phaseQ;
    end
    assign expPhaseHigh = phaseQ;
    // Low half while the phase is high, high half while it is low.
    always_comb begin
        if (noMux || phaseQ) begin
            expInHalf = sumWord[15:0];
        end else begin
            expInHalf = sumWord[31:16];
        end
    end
endmodule

// ===== tb_convolver_gain_and_expansion.sv
`timescale 1ns/1ps
module tb_convolver_gain_and_expansion
    import conv_gain_pkg::*;
    ;
    // One gain case: mode C, gain, accumulator, expected result and flag.
    typedef struct packed {
        logic [7:0] modeC;
        logic [3:0] gain;
        logic [31:0] acc;
        logic [15:0] out;
        logic ovf;
    } row_t;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h00000000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData;
    logic program_strobe_n = 1'b1;
    logic line_sync_input = 1'b1;
    logic cascadeHeadN = 1'b1;
    logic [31:0] accResult = 32'h00000000;
    logic [31:0] expWord = 32'h00000000; // Partial sum the neighbour sends.
    logic noMux = 1'b0;
    logic [15:0] expInHalf;
    logic expPhaseHigh;
    logic [7:0] pixelIn = 8'h00;
    logic [7:0] line_delay_pixel_bus;
    logic [15:0] resultOut;
    logic [15:0] expOutHalf;
    logic [1:0] field_indicator;
    logic overflowFlag;
    logic masterMode;
    logic [7:0] storePixel;
    int miscompares = 0;
    int checkCount = 0;
    row_t rows[14];

    convolver_gain_and_expansion i_convolver_gain_and_expansion (.clock(clock), .rstn(rstn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .program_strobe_n(program_strobe_n),
        .line_sync_input(line_sync_input), .cascadeHeadN(cascadeHeadN),
        .accResult(accResult), .expInHalf(expInHalf), .expPhaseHigh(expPhaseHigh),
        .pixelIn(pixelIn), .line_delay_pixel_bus(line_delay_pixel_bus),
        .resultOut(resultOut), .expOutHalf(expOutHalf), .field_indicator(field_indicator),
        .overflowFlag(overflowFlag), .masterMode(masterMode), .storePixel(storePixel));

    cascade_partner i_cascade_partner (.clock(clock), .sumWord(expWord), .noMux(noMux),
        .expInHalf(expInHalf), .expPhaseHigh(expPhaseHigh));

    // Free-running 250 MHz clock.
    always #2 clock = ~clock;

    // A pixel ramp makes any pipeline depth visible as a fixed difference.
    always @(posedge clock) pixelIn <= pixelIn + 8'h01;

    // Compare one value and count it; four-state compare so X never matches.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic results();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle write strobe beside address and data.
    task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= {24'h000000, d};
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    // One-cycle read strobe; data is only valid in the following cycle.
    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask

    // Let the pipeline settle, then sample just after an edge.
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Sync and program pins pass a synchroniser, so pulses are kept wide.
    task automatic syncPulse();
        @(posedge clock);
        line_sync_input <= 1'b0;
        repeat (4) @(posedge clock);
        line_sync_input <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    task automatic strobePulse();
        @(posedge clock);
        program_strobe_n <= 1'b0;
        repeat (4) @(posedge clock);
        program_strobe_n <= 1'b1;
    endtask

    // Watchdog sized well beyond the several hundred cycles the tests need.
    initial begin
        #100000;
        miscompares++;
        results();
    end

    initial begin
        logic [31:0] rd;
        logic [7:0] dly;
        rows = '{'{8'h00, 4'h1, 32'h12345678, 16'h1234, 1'b0},
            '{8'h10, 4'h1, 32'h01234567, 16'h1234, 1'b0},
            '{8'h20, 4'h1, 32'h00123456, 16'h1234, 1'b0},
            '{8'h30, 4'h1, 32'h00012345, 16'h1234, 1'b0},
            '{8'h00, 4'h0, 32'h12345678, 16'h0000, 1'b0},
            '{8'h30, 4'hF, 32'h00012345, 16'h1110, 1'b1},
            '{8'h31, 4'hF, 32'h00012345, 16'h7FFF, 1'b1},
            '{8'h32, 4'hF, 32'h00012345, 16'h7FFF, 1'b1},
            '{8'h30, 4'h1, 32'hFFFF0000, 16'hF000, 1'b0},
            '{8'h31, 4'h1, 32'hFFFF0000, 16'h0000, 1'b0},
            '{8'h32, 4'h1, 32'hFFFF0000, 16'hF000, 1'b0},
            '{8'h30, 4'h2, 32'hFFF80000, 16'h0000, 1'b1},
            '{8'h32, 4'h2, 32'hFFF80000, 16'h8000, 1'b1},
            '{8'h33, 4'h2, 32'hFFF80000, 16'h0000, 1'b1}};
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        // Register access, including an unmapped place.
        regRead(SCALE_ADDR, rd);
        check("scale reset", rd, 32'h00000001);
        regWrite(SCALE_ADDR, 8'h05);
        regRead(SCALE_ADDR, rd);
        check("scale", rd, 32'h00000005);
        regWrite(4'hC, 8'hFF);
        regRead(4'hC, rd);
        check("unmapped", rd, 32'h00000000);
        // Gain table with the expansion adder off so the sum is the accumulator.
        regWrite(MODE_A_ADDR, 8'h01);
        foreach (rows[i]) begin
            regWrite(MODE_C_ADDR, rows[i].modeC);
            regWrite(SCALE_ADDR, {4'h0, rows[i].gain});
            accResult <= rows[i].acc;
            settle(6);
            check("resultOut", {16'h0, resultOut}, {16'h0, rows[i].out});
            check("overflowFlag", {31'h0, overflowFlag}, {31'h0, rows[i].ovf});
        end
        $display("gain table done");
        // No sync has fallen yet, so the line-delay bus is still blank.
        check("line bus idle", {24'h0, line_delay_pixel_bus}, 32'h0);
        // Automatic selection: held off for ten syncs, then climbs only.
        regWrite(MODE_C_ADDR, 8'h40);
        regWrite(SCALE_ADDR, 8'h01);
        accResult <= 32'h00100000;
        strobePulse();
        repeat (9) syncPulse();
        settle(8);
        check("field_indicator", {30'h0, field_indicator}, 32'h3);
        check("line bus", {24'h0, line_delay_pixel_bus}, {24'h0, pixelIn - 8'h05});
        syncPulse();
        settle(8);
        check("field_indicator", {30'h0, field_indicator}, 32'h2);
        check("resultOut", {16'h0, resultOut}, 32'h1000);
        accResult <= 32'h00000010;
        syncPulse();
        settle(8);
        check("field_indicator", {30'h0, field_indicator}, 32'h2);
        accResult <= 32'h01000000;
        syncPulse();
        settle(8);
        check("field_indicator", {30'h0, field_indicator}, 32'h1);
        accResult <= 32'h08000000;
        syncPulse();
        settle(8);
        check("field_indicator", {30'h0, field_indicator}, 32'h0);
        // Manual selection still reports the automatic choice.
        regWrite(MODE_C_ADDR, 8'h20);
        accResult <= 32'h00123456;
        syncPulse();
        settle(8);
        check("field_indicator", {30'h0, field_indicator}, 32'h0);
        check("resultOut", {16'h0, resultOut}, 32'h1234);
        strobePulse();
        settle(8);
        check("field_indicator", {30'h0, field_indicator}, 32'h3);
        // Status: flush count ten, no overflow, not master, lowest field.
        regRead(STATUS_ADDR, rd);
        check("status", rd, 32'h000000A3);
        $display("auto select done");
        // Expansion adder and bus halves.
        regWrite(MODE_A_ADDR, 8'h00);
        regWrite(MODE_C_ADDR, 8'h00);
        accResult <= 32'h00010002;
        expWord <= 32'h00030004;
        settle(8);
        // Line up with the high phase, in which the low half stands.
        if (expPhaseHigh !== 1'b1) settle(1);
        check("expOutHalf low", {16'h0, expOutHalf}, 32'h0006);
        check("resultOut", {16'h0, resultOut}, 32'h0004);
        settle(1);
        check("expOutHalf high", {16'h0, expOutHalf}, 32'h0004);
        regWrite(MODE_A_ADDR, 8'h01);
        settle(8);
        if (expPhaseHigh !== 1'b1) settle(1);
        check("expOutHalf", {16'h0, expOutHalf}, 32'h0002);
        // Non-multiplexed bus with raw output and no overflow handling.
        regWrite(MODE_A_ADDR, 8'h81);
        noMux <= 1'b1;
        regWrite(MODE_C_ADDR, 8'h05);
        regWrite(SCALE_ADDR, 8'h0F);
        accResult <= 32'h00012345;
        settle(8);
        check("expOutHalf", {16'h0, expOutHalf}, 32'h2345);
        check("resultOut", {16'h0, resultOut}, 32'h2345);
        check("overflowFlag", {31'h0, overflowFlag}, 32'h0);
        @(negedge clock);
        #1;
        check("expOutHalf", {16'h0, expOutHalf}, 32'h2345);
        // Extra expansion delay: a new partial sum reaches the pins six cycles later, four more than without it.
        regWrite(MODE_A_ADDR, 8'h82);
        accResult <= 32'h00000000;
        expWord <= 32'h00000011;
        settle(3);
        check("expOutHalf delayed", {16'h0, expOutHalf}, 32'h0004);
        settle(3);
        check("expOutHalf delayed", {16'h0, expOutHalf}, 32'h0011);
        $display("expansion done");
        // Cascade head by pin and by mode bit.
        check("masterMode", {31'h0, masterMode}, 32'h0);
        @(posedge clock);
        cascadeHeadN <= 1'b0;
        settle(6);
        check("masterMode", {31'h0, masterMode}, 32'h1);
        @(posedge clock);
        cascadeHeadN <= 1'b1;
        regWrite(MODE_A_ADDR, 8'h04);
        settle(6);
        check("masterMode", {31'h0, masterMode}, 32'h1);
        $display("master done");
        // Pixel input delay and expansion delay add into one store delay.
        for (int b = 0; b < 2; b++) begin
            for (int d = 0; d < 4; d++) begin
                regWrite(MODE_B_ADDR, 8'(b * 8));
                regWrite(MODE_D_ADDR, 8'(d * 4));
                settle(24);
                dly = 8'(2 + 4 * b + 4 * d);
                check("storePixel", {24'h0, storePixel}, {24'h0, pixelIn - dly});
            end
        end
        $display("pixel delay done");
        results();
    end
endmodule
